/* design/fcd_decoder.sv */
// command decoder and operation control for a 16-bit parallel flash
// assumes write strobe, pins and engine handshakes are synchronous to clk_in
`timescale 1ns/10ps
`default_nettype none
module fcd_decoder
   import fcd_pkg::*;
#(
   parameter int ADDR_W    = 23,
   parameter int BUF_DEPTH = 32
)
(
   input  wire logic                         clk_in,
   input  wire logic                         rst_in,
   input  wire logic                         wr_in,
   input  wire logic [ADDR_W-1:0]            wr_addr_in,
   input  wire logic [15:0]                  wr_data_in,
   input  wire logic                         ce_n_in,
   input  wire logic                         oe_n_in,
   input  wire logic                         address_valid_n_in,
   input  wire logic                         sync_read_in,
   input  wire logic                         eng_done_in,
   input  wire logic [3:0]                   eng_err_in,
   input  wire logic [$clog2(BUF_DEPTH)-1:0] buf_rd_idx_in,
   output var  logic [1:0]                   read_state_out,
   output var  logic [7:0]                   status_view_out,
   output var  logic [7:0]                   status_byte_out,
   output var  logic                         op_start_out,
   output var  logic [1:0]                   op_kind_out,
   output var  logic [ADDR_W-1:0]            op_addr_out,
   output var  logic [15:0]                  op_data_out,
   output var  logic [$clog2(BUF_DEPTH)-1:0] op_count_out,
   output var  logic                         suspend_out,
   output var  logic                         factory_mode_out,
   output var  logic [15:0]                  buf_rd_data_out
);
   localparam int IW = $clog2(BUF_DEPTH);

   fcd_state_t     state;
   fcd_state_t     next_state;
   fcd_read_t      next_read;
   fcd_op_t        next_kind;
   logic [7:0]     code;
   logic [7:0]     next_status;
   logic [7:0]     set_mask;
   logic [7:0]     clr_mask;
   logic           start_ev;
   logic           seq_err;
   logic           clear_ev;
   logic           buf_we;
   logic [IW-1:0]  buf_idx;
   logic [IW-1:0]  words_left;
   logic           ce_q;
   logic           oe_q;
   logic           adv_q;
   logic           refresh;

   assign code = wr_data_in[7:0];

   // read-mode commands shared by the idle and suspended states
   function automatic fcd_read_t read_cmd(input logic [7:0] c, input fcd_read_t cur);
      fcd_read_t r;
      case (c)
         CMD_READ_ARRAY:  r = RD_ARRAY;
         CMD_READ_STATUS: r = RD_STATUS;
         CMD_READ_ID:     r = RD_ID;
         CMD_READ_QUERY:  r = RD_QUERY;
         default:         r = cur;
      endcase
      return r;
   endfunction

   always_comb
   begin
      next_state = state;
      next_read  = fcd_read_t'(read_state_out);
      next_kind  = fcd_op_t'(op_kind_out);
      start_ev   = 1'b0;
      seq_err    = 1'b0;
      clear_ev   = 1'b0;
      buf_we     = 1'b0;
      unique case (state)
         ST_READY:
         begin
            if (wr_in)
            begin
               next_read = read_cmd(code, next_read);
               clear_ev  = (code == CMD_CLEAR);
               if (code == CMD_WORD_PGM || code == CMD_WORD_PGM_ALT)
                  next_state = ST_PGM_SETUP;
               else if (code == CMD_BUF_PGM)
                  next_state = ST_BUF_COUNT;
               else if (code == CMD_FACTORY)
                  next_state = ST_FAC_SETUP;
               else if (code == CMD_ERASE)
                  next_state = ST_ERS_SETUP;
               if (next_state != ST_READY)
                  next_read = RD_STATUS;
            end
         end
         ST_PGM_SETUP:
         begin
            if (wr_in)
            begin
               next_state = ST_BUSY;
               next_kind  = OP_WORD;
               start_ev   = 1'b1;
            end
         end
         ST_BUF_COUNT:
         begin
            if (wr_in)
            begin
               next_state = ST_BUF_DATA;
               if (wr_data_in > 16'(BUF_DEPTH - 1))
               begin
                  next_state = ST_READY;
                  seq_err    = 1'b1;
               end
            end
         end
         ST_BUF_DATA:
         begin
            buf_we = wr_in;
            if (wr_in && words_left == '0)
               next_state = ST_BUF_CONF;
         end
         ST_BUF_CONF, ST_FAC_SETUP:
         begin
            if (wr_in)
            begin
               next_state = ST_READY;
               seq_err    = (code != CMD_CONFIRM);
               if (code == CMD_CONFIRM)
               begin
                  next_state = (state == ST_FAC_SETUP) ? ST_FAC_RUN : ST_BUSY;
                  next_kind  = (state == ST_FAC_SETUP) ? OP_FACTORY : OP_BUFFER;
                  start_ev   = 1'b1;
               end
            end
         end
         ST_ERS_SETUP:
         begin
            if (wr_in)
            begin
               next_state = ST_READY;
               next_read  = RD_STATUS;
               seq_err    = (code != CMD_CONFIRM);
               if (code == CMD_CONFIRM)
               begin
                  next_state = ST_BUSY;
                  next_kind  = OP_ERASE;
                  start_ev   = 1'b1;
               end
            end
         end
         ST_BUSY:
         begin
            // only status read and suspend are honoured here
            if (eng_done_in)
               next_state = ST_READY;
            else if (wr_in && code == CMD_READ_STATUS)
               next_read = RD_STATUS;
            else if (wr_in && code == CMD_SUSPEND)
            begin
               next_state = ST_SUSPENDED;
               next_read  = RD_STATUS;
            end
         end
         ST_FAC_RUN:
         begin
            // factory mode streams data; no write is decoded as a command
            buf_we = wr_in;
            if (eng_done_in)
               next_state = ST_READY;
         end
         ST_SUSPENDED:
         begin
            // pins never end suspend; only resume or reset do
            if (wr_in)
            begin
               next_read = read_cmd(code, next_read);
               clear_ev  = (code == CMD_CLEAR);
               if (code == CMD_CONFIRM)
                  next_state = ST_BUSY;
            end
         end
         default:
            next_state = ST_READY;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state          <= ST_READY;
         read_state_out <= RD_ARRAY;
      end
      else
      begin
         state          <= next_state;
         read_state_out <= next_read;
      end
   end

   // operation launch: address and data are those of the confirming write
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         op_start_out     <= 1'b0;
         op_kind_out      <= OP_WORD;
         op_addr_out      <= '0;
         op_data_out      <= '0;
         op_count_out     <= '0;
         suspend_out      <= 1'b0;
         factory_mode_out <= 1'b0;
      end
      else
      begin
         op_start_out     <= start_ev;
         op_kind_out      <= next_kind;
         suspend_out      <= (next_state == ST_SUSPENDED);
         factory_mode_out <= (next_state == ST_FAC_RUN);
         if (start_ev)
         begin
            op_addr_out <= wr_addr_in;
            op_data_out <= wr_data_in;
         end
         if (state == ST_BUF_COUNT && wr_in)
            op_count_out <= wr_data_in[IW-1:0];
      end
   end

   // buffer fill position, restarted on every count or factory start
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         buf_idx    <= '0;
         words_left <= '0;
      end
      else if (state == ST_BUF_COUNT || start_ev)
      begin
         buf_idx    <= '0;
         words_left <= wr_data_in[IW-1:0];
      end
      else if (buf_we)
      begin
         buf_idx    <= buf_idx + 1'b1;
         words_left <= words_left - 1'b1;
      end
   end

   fcd_wbuf #(
      .WIDTH (16),
      .DEPTH (BUF_DEPTH)
   ) u_wbuf (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .wr_en_in    (buf_we),
      .wr_idx_in   (buf_idx),
      .wr_data_in  (wr_data_in),
      .rd_idx_in   (buf_rd_idx_in),
      .rd_data_out (buf_rd_data_out)
   );

   // set wins over a clear written in the same cycle
   always_comb
   begin
      set_mask = '0;
      if (eng_done_in && (state == ST_BUSY || state == ST_FAC_RUN))
      begin
         set_mask[SB_ERASE_ERR] = eng_err_in[3];
         set_mask[SB_PGM_ERR]   = eng_err_in[2];
         set_mask[SB_VPP_ERR]   = eng_err_in[1];
         set_mask[SB_LOCK_ERR]  = eng_err_in[0];
      end
      if (seq_err)
      begin
         set_mask[SB_ERASE_ERR] = 1'b1;
         set_mask[SB_PGM_ERR]   = 1'b1;
      end
      clr_mask    = clear_ev ? ERR_MASK : 8'h00;
      next_status = (status_byte_out & ~clr_mask) | set_mask;
      next_status[SB_READY]      = !(next_state == ST_BUSY || next_state == ST_FAC_RUN);
      next_status[SB_PGM_SUSP]   = (next_state == ST_SUSPENDED) && (next_kind != OP_ERASE);
      next_status[SB_ERASE_SUSP] = (next_state == ST_SUSPENDED) && (next_kind == OP_ERASE);
      next_status[0]             = 1'b0;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         status_byte_out <= STATUS_RESET;
      end
      else
      begin
         status_byte_out <= next_status;
      end
   end

   // the visible status is a snapshot taken when a new read cycle begins
   assign refresh = (ce_q && !ce_n_in)
                  || (!sync_read_in && oe_q && !oe_n_in)
                  || (sync_read_in && adv_q && !address_valid_n_in);

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ce_q            <= 1'b1;
         oe_q            <= 1'b1;
         adv_q           <= 1'b1;
         status_view_out <= STATUS_RESET;
      end
      else
      begin
         ce_q  <= ce_n_in;
         oe_q  <= oe_n_in;
         adv_q <= address_valid_n_in;
         if (refresh)
            status_view_out <= status_byte_out;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_array_read: assert property (state == ST_READY && wr_in && code == CMD_READ_ARRAY
      |=> read_state_out == RD_ARRAY) else $error("array read not selected");
   a_status_read: assert property (state == ST_READY && wr_in && code == CMD_READ_STATUS
      |=> read_state_out == RD_STATUS) else $error("status read not selected");
   a_auto_status: assert property (state == ST_READY && wr_in
      && (code == CMD_WORD_PGM || code == CMD_ERASE)
      |=> read_state_out == RD_STATUS) else $error("no automatic status read");
   a_id_read: assert property (state == ST_READY && wr_in && code == CMD_READ_ID
      |=> read_state_out == RD_ID) else $error("identifier read not selected");
   a_id_query: assert property (state == ST_READY && wr_in && code == CMD_READ_QUERY
      |=> read_state_out == RD_QUERY) else $error("query read not selected");
   a_err_sticky: assert property ($fell(status_byte_out[SB_PGM_ERR])
      |-> $past(clear_ev)) else $error("error bit cleared without clear");
   a_word_start: assert property (state == ST_PGM_SETUP && wr_in
      |=> op_start_out && op_kind_out == OP_WORD && op_addr_out == $past(wr_addr_in)
      ##1 !op_start_out) else $error("word program not launched");
   a_busy_ignore: assert property (state == ST_BUSY && wr_in && !eng_done_in
      && code != CMD_READ_STATUS && code != CMD_SUSPEND
      |=> state == ST_BUSY && $stable(read_state_out) && !op_start_out)
      else $error("command taken while busy");
   a_erase_seq: assert property (state == ST_ERS_SETUP && wr_in && code != CMD_CONFIRM
      |=> status_byte_out[5:4] == 2'b11 && read_state_out == RD_STATUS)
      else $error("bad erase confirm not flagged");
   a_suspend_ok: assert property (state == ST_BUSY && wr_in && code == CMD_SUSPEND
      && !eng_done_in |=> suspend_out && status_byte_out[SB_READY]
      && (status_byte_out[SB_PGM_SUSP] ^ status_byte_out[SB_ERASE_SUSP]))
      else $error("suspend not reported");
   a_ready_low: assert property (op_start_out |-> !status_byte_out[SB_READY])
      else $error("ready high while engine starts");
   a_view_hold: assert property (!refresh |=> $stable(status_view_out))
      else $error("status view changed without toggle");

   c_word_pgm: cover property (state == ST_PGM_SETUP && wr_in ##[1:100] eng_done_in);
   c_suspend: cover property (state == ST_SUSPENDED && wr_in && code == CMD_CONFIRM);
   c_buf_conf: cover property (state == ST_BUF_CONF && wr_in && code == CMD_CONFIRM);
   c_factory: cover property (state == ST_FAC_RUN && wr_in);
endmodule
`default_nettype wire

/* design/fcd_pkg.sv */
// command codes, status layout and state types for the flash command decoder
// assumes a single 50 MHz clock domain; shared by the decoder and its buffer
// Overview of operation
// - code ff selects array read, 16 bits
// - code 70 selects status read, low byte
// - program or erase commands switch to status read
// - code 90 selects identifier read, 16 bits
// - code 98 selects query read, low byte
// - engine sets error bits; only 50 clears
// - word program latches next write, starts engine
// - code 10 behaves as code 40
// - async status refreshes on chip or output toggle
// - sync status refreshes on chip or strobe toggle
// - code e8 loads up to 32 buffer words
// - confirm d0 makes engine program the buffer
// - d0 after 80 latches and starts factory mode
// - bad erase confirm sets bits 4,5, status read
// - d0 after 20 erases the addressed block
// - while erasing accept only status and suspend
// - b0 suspends; sets bit 2 or 6, ready
// - suspend holds regardless of control inputs
// - d0 while suspended resumes the operation
// - reset gives array read, status 80
package fcd_pkg;
   localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_READ_ID     = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY  = 8'h98;
   localparam logic [7:0] CMD_CLEAR       = 8'h50;
   localparam logic [7:0] CMD_WORD_PGM    = 8'h40;
   localparam logic [7:0] CMD_WORD_PGM_ALT= 8'h10;
   localparam logic [7:0] CMD_BUF_PGM     = 8'he8;
   localparam logic [7:0] CMD_FACTORY     = 8'h80;
   localparam logic [7:0] CMD_ERASE       = 8'h20;
   localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
   localparam logic [7:0] CMD_SUSPEND     = 8'hb0;
   localparam int         SB_READY        = 7;
   localparam int         SB_ERASE_SUSP   = 6;
   localparam int         SB_ERASE_ERR    = 5;
   localparam int         SB_PGM_ERR      = 4;
   localparam int         SB_VPP_ERR      = 3;
   localparam int         SB_PGM_SUSP     = 2;
   localparam int         SB_LOCK_ERR     = 1;
   localparam logic [7:0] STATUS_RESET    = 8'h80;
   localparam logic [7:0] ERR_MASK        = 8'h3a;
   typedef enum logic [1:0] {
      RD_ARRAY  = 2'b00,
      RD_STATUS = 2'b01,
      RD_ID     = 2'b10,
      RD_QUERY  = 2'b11
   } fcd_read_t;
   typedef enum logic [1:0] {
      OP_WORD    = 2'b00,
      OP_BUFFER  = 2'b01,
      OP_FACTORY = 2'b10,
      OP_ERASE   = 2'b11
   } fcd_op_t;
   typedef enum logic [3:0] {
      ST_READY     = 4'b0000,
      ST_PGM_SETUP = 4'b0001,
      ST_BUF_COUNT = 4'b0010,
      ST_BUF_DATA  = 4'b0011,
      ST_BUF_CONF  = 4'b0100,
      ST_FAC_SETUP = 4'b0101,
      ST_ERS_SETUP = 4'b0110,
      ST_BUSY      = 4'b0111,
      ST_FAC_RUN   = 4'b1000,
      ST_SUSPENDED = 4'b1001
   } fcd_state_t;
endpackage

/* design/fcd_wbuf.sv */
// program buffer: flip-flop storage written by index, read by index
// assumes writes and reads come from the clk_in domain
`timescale 1ns/10ps
`default_nettype none
module fcd_wbuf
   import fcd_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
)
(
   input  wire logic                     clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     wr_en_in,
   input  wire logic [$clog2(DEPTH)-1:0] wr_idx_in,
   input  wire logic [WIDTH-1:0]         wr_data_in,
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx_in,
   output var  logic [WIDTH-1:0]         rd_data_out
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_in)
   begin
      if (wr_en_in)
      begin
         mem[wr_idx_in] <= wr_data_in;
      end
   end

   // registered read so the engine side sees a flop output
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rd_data_out <= '0;
      end
      else
      begin
         rd_data_out <= mem[rd_idx_in];
      end
   end
endmodule
`default_nettype wire

/* verif/fcd_decoder_bench.sv */
// self-checking bench for the flash command decoder with an engine model
// assumes inputs change on the falling edge; starts are matched from a queue
`timescale 1ns/10ps
`default_nettype none
module fcd_decoder_bench
   import fcd_pkg::*;
;
   logic        clk_in, rst_in, wr_in, ce_n, oe_n, adv_n, sync_rd, eng_done;
   logic        op_start, suspend, factory;
   logic [22:0] addr, op_addr;
   logic [15:0] data, op_data, buf_word, last;
   logic [7:0]  lat, status_view, status_byte, vexp;
   logic [3:0]  err, eng_err;
   logic [4:0]  rd_idx, op_count;
   logic [1:0]  read_state, op_kind;
   logic [24:0] note;
   logic [24:0] exp_q[$];
   logic [31:0] rnd;
   int          failures, checks;
   logic [7:0]  rd_cmd[4] = '{CMD_READ_STATUS, CMD_READ_ID, CMD_READ_QUERY, CMD_READ_ARRAY};
   logic [1:0]  rd_exp[4] = '{RD_STATUS, RD_ID, RD_QUERY, RD_ARRAY};

   fcd_decoder i_dut (.clk_in(clk_in), .rst_in(rst_in), .wr_in(wr_in), .wr_addr_in(addr),
      .wr_data_in(data), .ce_n_in(ce_n), .oe_n_in(oe_n), .address_valid_n_in(adv_n),
      .sync_read_in(sync_rd), .eng_done_in(eng_done), .eng_err_in(eng_err),
      .buf_rd_idx_in(rd_idx), .read_state_out(read_state), .status_view_out(status_view),
      .status_byte_out(status_byte), .op_start_out(op_start), .op_kind_out(op_kind),
      .op_addr_out(op_addr), .op_data_out(op_data), .op_count_out(op_count),
      .suspend_out(suspend), .factory_mode_out(factory), .buf_rd_data_out(buf_word));
   fcd_engine_model i_eng (.clk_in(clk_in), .rst_in(rst_in), .start_in(op_start),
      .suspend_in(suspend), .lat_in(lat), .err_in(err), .count_in(op_count),
      .done_out(eng_done), .err_out(eng_err), .idx_out(rd_idx));

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   task automatic report_and_stop;
      if (failures == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one host write per call; back to back calls keep the strobe high
   task automatic w(input logic [15:0] d);
      wr_in = 1'b1;
      data  = d;
      @(negedge clk_in);
   endtask
   task automatic rel(input int n);
      wr_in = 1'b0;
      repeat (n) @(negedge clk_in);
   endtask
   task automatic wait_ready;
      int i;
      for (i = 0; i < 300 && !(status_byte[7] === 1'b1 && factory === 1'b0); i++)
         @(negedge clk_in);
      if (i == 300)
      begin
         check(16'h0001, 16'h0000, "engine wait timed out");
         report_and_stop();
      end
   endtask
   task automatic pulse(input bit use_oe);
      if (use_oe)
         oe_n = 1'b0;
      else
         adv_n = 1'b0;
      repeat (2) @(negedge clk_in);
      oe_n  = 1'b1;
      adv_n = 1'b1;
      @(negedge clk_in);
   endtask

   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   // each start pulse is high for one whole cycle, so one falling-edge look sees it
   always @(negedge clk_in)
      if (op_start === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(16'h0001, 16'h0000, "unexpected start");
         else
         begin
            note = exp_q.pop_front();
            check(op_kind, note[24:23], "op kind");
            check(op_addr[15:0], note[15:0], "op addr");
            check(16'(op_addr[22:16]), 16'(note[22:16]), "op addr high");
         end
      end

   initial
   begin
      rst_in = 1'b1;
      wr_in = 1'b0;
      addr = 23'h000000;
      data = 16'h0000;
      ce_n = 1'b0;
      oe_n = 1'b1;
      adv_n = 1'b1;
      sync_rd = 1'b0;
      lat = 8'h40;
      err = 4'h0;
      failures = 0;
      checks = 0;
      rnd = 32'h00000010;
      vexp = STATUS_RESET;
      repeat (3) @(negedge clk_in);
      rst_in = 1'b0;
      check(read_state, RD_ARRAY, "reset read state");
      check(status_byte, STATUS_RESET, "reset status");
      check(status_view, STATUS_RESET, "reset view");
      foreach (rd_cmd[i])
      begin
         w(rd_cmd[i]);
         rel(1);
         check(read_state, rd_exp[i], "read command");
      end
      // word program, async then sync view refresh, with sticky errors
      for (int k = 0; k < 2; k++)
      begin
         rnd = xs(rnd);
         addr = rnd[22:0];
         err = k ? 4'h2 : 4'h4;
         exp_q.push_back({OP_WORD, addr});
         w(k ? CMD_WORD_PGM_ALT : CMD_WORD_PGM);
         w(rnd[31:16]);
         w(CMD_READ_ID);
         rel(1);
         check(op_data, rnd[31:16], "word data");
         check(read_state, RD_STATUS, "busy refuses read id");
         check(status_byte[7], 1'b0, "ready low while busy");
         wait_ready();
         check(status_byte, k ? 8'h88 : 8'h90, "error bits");
         sync_rd = k[0];
         pulse(k[0]);
         check(status_view, vexp, "view held");
         pulse(!k[0]);
         vexp = k ? 8'h88 : 8'h90;
         check(status_view, vexp, "view refreshed");
         w(CMD_READ_STATUS);
         rel(1);
         check(status_byte, vexp, "errors sticky");
         w(CMD_CLEAR);
         w(CMD_READ_ARRAY);
         rel(1);
         check(status_byte, STATUS_RESET, "cleared");
         check(read_state, RD_ARRAY, "back to array");
      end
      // program then erase: refused code, suspend, pins wiggled, resume
      err = 4'h0;
      for (int j = 0; j < 2; j++)
      begin
         exp_q.push_back({j ? OP_ERASE : OP_WORD, addr});
         w(j ? CMD_ERASE : CMD_WORD_PGM);
         w(j ? {8'h00, CMD_CONFIRM} : rnd[15:0]);
         w(j ? CMD_WORD_PGM : CMD_ERASE);
         w(CMD_SUSPEND);
         rel(1);
         check(suspend, 1'b1, "suspended");
         check(status_byte, j ? 8'hc0 : 8'h84, "suspend bits");
         for (int i = 0; i < 8; i++)
         begin
            rnd = xs(rnd);
            {ce_n, oe_n, adv_n, sync_rd} = rnd[3:0];
            @(negedge clk_in);
         end
         {ce_n, oe_n, adv_n, sync_rd} = 4'h6;
         check(suspend, 1'b1, "suspend holds");
         w(CMD_CONFIRM);
         rel(1);
         check(suspend, 1'b0, "resumed");
         check(status_byte[7], 1'b0, "busy again");
         wait_ready();
         check(status_byte, STATUS_RESET, "op finished");
      end
      // wrong erase confirm, oversize buffer count, wrong factory confirm
      for (int j = 0; j < 3; j++)
      begin
         w(j == 2 ? CMD_FACTORY : j ? CMD_BUF_PGM : CMD_ERASE);
         w(j == 1 ? 16'h0020 : {8'h00, CMD_READ_ARRAY});
         rel(1);
         check(status_byte, 8'hb0, "sequence error");
         check(read_state, RD_STATUS, "status after error");
         w(CMD_CLEAR);
      end
      // full 32-word buffer
      exp_q.push_back({OP_BUFFER, addr});
      w(CMD_BUF_PGM);
      w(16'h001f);
      for (int i = 0; i < 32; i++)
      begin
         rnd = xs(rnd);
         last = rnd[15:0];
         w(last);
      end
      w(CMD_CONFIRM);
      rel(2);
      check(op_count, 5'h1f, "buffer count");
      check(buf_word, last, "last buffer word");
      wait_ready();
      // factory mode takes commands as data
      exp_q.push_back({OP_FACTORY, addr});
      w(CMD_FACTORY);
      w(CMD_CONFIRM);
      w(CMD_READ_ARRAY);
      w(CMD_SUSPEND);
      rel(1);
      check(factory, 1'b1, "factory running");
      check(suspend, 1'b0, "factory ignores suspend");
      check(read_state, RD_STATUS, "factory ignores read");
      wait_ready();
      rel(3);
      check(16'(exp_q.size()), 16'h0000, "starts missing");
      report_and_stop();
   end
endmodule
`default_nettype wire

/* verif/fcd_engine_model.sv */
// write engine model: answers each start with a done pulse lat_in plus one cycles after the start
// assumes decoder outputs change on rising clk_in; count is frozen while suspended
`timescale 1ns/10ps
`default_nettype none
module fcd_engine_model
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       start_in,
   input  wire logic       suspend_in,
   input  wire logic [7:0] lat_in,
   input  wire logic [3:0] err_in,
   input  wire logic [4:0] count_in,
   output var  logic       done_out,
   output var  logic [3:0] err_out,
   output var  logic [4:0] idx_out
);
   logic [7:0] left;
   logic       run;
   // reads the last buffered word so the bench can see what was stored
   assign idx_out = count_in;
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         run      <= 1'b0;
         left     <= 8'h00;
         done_out <= 1'b0;
         err_out  <= 4'h0;
      end
      else
      begin
         done_out <= 1'b0;
         err_out  <= 4'h0;
         if (start_in)
         begin
            run  <= 1'b1;
            left <= lat_in;
         end
         else if (run && !suspend_in)
         begin
            if (left == 8'h00)
            begin
               run      <= 1'b0;
               done_out <= 1'b1;
               err_out  <= err_in;
            end
            else
               left <= left - 8'h01;
         end
      end
   end
endmodule
`default_nettype wire
